// File: ref_defines.vh
`ifndef REF_DEFINES_VH
`define REF_DEFINES_VH
// Summary of operation
// R01 - Curve bank switch 4 off offers definite, standard, very, extreme, long, short, rectifier.
// R02 - Curve bank switch 4 on offers moderate, very, extreme, two short variants, electromechanical.
// R03 - Reset-mode switch off clears stage-one delay instantly; on unwinds it inversely.
// R04 - One reset-mode choice serves both phase and earth first stages.
// R05 - Earth stage-one threshold is range minimum plus weights; minima 0.05 and 1.5.
// R06 - Earth second stage is definite time only, no inverse curve.
// R07 - Source switch off uses the I/O switch bank; on uses software settings.
// R08 - First switch input set: input one blocks phase stage two, input two resets.
// R09 - Second switch input set: input one is auxiliary trip, input two resets.
// R10 - Software input set maps each input to any combination of functions.
// R11 - Output blocking input holds every relay unpowered.
// R12 - Latched-output reset input rising releases every latched relay.
// R13 - Indicator reset input rising clears trip indicators only without trip cause.
// R14 - Stage blocking input resets that stage's running delay.
// R15 - Auxiliary input rising lights latched auxiliary indicator and acts as trip.
// R16 - Breaker-not-ready input refuses serial breaker close commands.
// R17 - First output set: relay one 0.4 s trip pulse, relay two follows trip. Code pulses relay one for 3 to 4 tick periods, 0.3 to 0.4 s.
// R18 - First output set: relay three held after trip, released early by reset.
// R19 - First output set: relay four follows phase stage-two start.
// R20 - Second set: relays one, three phase and aux trips; two, four earth trips.
// R21 - Software output set makes each relay latching or not independently.
// R22 - Hold time is 0 to 6500 minutes, default 4320.
// R23 - Inputs sampled on the clock; all timers run from one slow tick.
// R24 - Output group switch off selects first set, on second, in switch mode.

// Register byte offsets
`define REF_ADR_STATUS 8'h00
`define REF_ADR_IN1MAP 8'h04
`define REF_ADR_IN2MAP 8'h08
`define REF_ADR_HOLD   8'h0c
`define REF_ADR_OUTMAP 8'h10
`define REF_ADR_LAST   8'h1c

// Input function bits
`define REF_FI_BLKOUT 0
`define REF_FI_RSTOUT 1
`define REF_FI_RSTLED 2
`define REF_FI_BLKP1  3
`define REF_FI_BLKP2  4
`define REF_FI_BLKE1  5
`define REF_FI_BLKE2  6
`define REF_FI_CLOSED 7
`define REF_FI_OPEN   8
`define REF_FI_AUX    9
`define REF_FI_NRDY   10
`define REF_IN1_DEF   11'h010
`define REF_IN2_DEF   11'h006

// Output source bits 0..13, bit 15 of an output map is the latch enable
`define REF_FO_LATCH  15
`define REF_OUT1_DEF  16'h0001
`define REF_OUT2_DEF  16'h0002
`define REF_OUT3_DEF  16'h0800
`define REF_OUT4_DEF  16'h0008
`define REF_G1_MAPS   56'h00_2080_0000_8001
`define REF_G2_MAPS   56'h0c_004c_00c0_04c0

// Threshold in 0.05 units of nominal earth current
`define REF_THR_MIN_LO 8'h01
`define REF_THR_MIN_HI 8'h1e

// Timing
`define REF_CLK_KHZ     250000
`define REF_TICK_MS     100
`define REF_TICK_CYCLES (`REF_TICK_MS * `REF_CLK_KHZ)
`define REF_PULSE_MS    400
`define REF_PULSE_TICKS (`REF_PULSE_MS / `REF_TICK_MS)
`define REF_CLOSE_MS    400
`define REF_CLOSE_TICKS (`REF_CLOSE_MS / `REF_TICK_MS)
`define REF_MIN_TICKS   (60000 / `REF_TICK_MS)
`define REF_HOLD_DEF    13'd4320
`define REF_HOLD_MAX    13'd6500
`endif

// File: ref_io_config.v
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`include "ref_defines.vh"
module ref_io_config #(
  parameter TICK_CYCLES = `REF_TICK_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        sw_char_group_i,
  input  wire [2:0]  sw_char_sel_i,
  input  wire        sw_reset_mode_i,
  input  wire        sw_io_source_i,
  input  wire        sw_input_set_i,
  input  wire        sw_output_set_i,
  input  wire [5:0]  sw_earth_thr_i,
  input  wire        binary_input_one_i,
  input  wire        binary_input_two_i,
  input  wire        phase_stage_one_trip_i,
  input  wire        phase_stage_two_trip_i,
  input  wire        earth_stage_one_trip_i,
  input  wire        earth_stage_two_trip_i,
  input  wire        phase_stage_one_start_i,
  input  wire        phase_stage_two_start_i,
  input  wire        earth_stage_one_start_i,
  input  wire        earth_stage_two_start_i,
  input  wire        watchdog_ok_i,
  input  wire        close_req_i,
  output reg  [3:0]  earth_curve_code_o,
  output reg         phase_reset_inverse_o,
  output reg         earth_reset_inverse_o,
  output reg  [7:0]  earth_thr_o,
  output reg         earth_stage_one_disable_o,
  output reg         block_phase_one_o,
  output reg         block_phase_two_o,
  output reg         block_earth_one_o,
  output reg         block_earth_two_o,
  output wire        output_relay_one_o,
  output wire        output_relay_two_o,
  output wire        output_relay_three_o,
  output wire        output_relay_four_o,
  output reg         trip_led_o,
  output reg         aux_led_o,
  output reg         breaker_closed_status_o,
  output reg         breaker_open_status_o,
  output reg         close_refused_o
);

  localparam TW = $clog2(TICK_CYCLES + 1);
  // Full-width integers first, then cut to the counter widths on purpose
  localparam [31:0]   TICK_W     = TICK_CYCLES - 1;
  localparam [31:0]   PULSE_W    = `REF_PULSE_TICKS;
  localparam [31:0]   CLOSE_W    = `REF_CLOSE_TICKS;
  localparam [31:0]   MIN_W      = `REF_MIN_TICKS - 1;
  localparam [TW-1:0] TICK_LAST  = TICK_W[TW-1:0];
  localparam [2:0]    PULSE_T    = PULSE_W[2:0];
  localparam [2:0]    CLOSE_T    = CLOSE_W[2:0];
  localparam [9:0]    MIN_LAST   = MIN_W[9:0];
  localparam [55:0]   G1_MAPS    = `REF_G1_MAPS;
  localparam [55:0]   G2_MAPS    = `REF_G2_MAPS;

  ////////////////////////////////////////////////////////////////////////////
  // Sampled switches and inputs
  reg        grp_r, rmode_r, usb_r, inset_r, outset_r;
  reg [2:0]  csel_r;
  reg [5:0]  thr_sw_r;
  reg        bi1_r, bi2_r, bi1_q, bi2_q;
  reg [3:0]  trip_r, start_r;
  reg        wdog_r, close_req_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      grp_r       <= 1'b0;
      rmode_r     <= 1'b0;
      usb_r       <= 1'b0;
      inset_r     <= 1'b0;
      outset_r    <= 1'b0;
      csel_r      <= 3'h0;
      thr_sw_r    <= 6'h00;
      bi1_r       <= 1'b0;
      bi2_r       <= 1'b0;
      bi1_q       <= 1'b0;
      bi2_q       <= 1'b0;
      trip_r      <= 4'h0;
      start_r     <= 4'h0;
      wdog_r      <= 1'b0;
      close_req_r <= 1'b0;
    end else if (ce_i) begin
      // Plain registering; inputs are already clock-synchronous  // see R23
      grp_r       <= sw_char_group_i;
      rmode_r     <= sw_reset_mode_i;
      usb_r       <= sw_io_source_i;
      inset_r     <= sw_input_set_i;
      outset_r    <= sw_output_set_i;
      csel_r      <= sw_char_sel_i;
      thr_sw_r    <= sw_earth_thr_i;
      bi1_r       <= binary_input_one_i;
      bi2_r       <= binary_input_two_i;
      bi1_q       <= bi1_r;
      bi2_q       <= bi2_r;
      trip_r      <= {earth_stage_two_trip_i, earth_stage_one_trip_i,
                      phase_stage_two_trip_i, phase_stage_one_trip_i};
      start_r     <= {earth_stage_two_start_i, earth_stage_one_start_i,
                      phase_stage_two_start_i, phase_stage_one_start_i};
      wdog_r      <= watchdog_ok_i;
      close_req_r <= close_req_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software settings over Wishbone
  reg [10:0] in1map_r, in2map_r;
  reg [12:0] hold_r;
  reg [15:0] outmap_r [0:3];
  wire [3:0] relay_r, latched_r;
  reg        hold_act_r;

  wire        acc    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr     = acc & wb_we_i;
  wire [31:0] wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        is_out = (wb_adr_i >= `REF_ADR_OUTMAP) &&
                       (wb_adr_i <= `REF_ADR_LAST) && (wb_adr_i[1:0] == 2'b00);
  wire [1:0]  oidx   = wb_adr_i[3:2];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [31:0] m;
    begin
      merge = (old & ~m) | (dat & m);
    end
  endfunction

  wire [31:0] in1_w  = merge({21'h0, in1map_r}, wb_dat_i, wmask);
  wire [31:0] in2_w  = merge({21'h0, in2map_r}, wb_dat_i, wmask);
  wire [31:0] hold_w = merge({19'h0, hold_r}, wb_dat_i, wmask);
  wire [31:0] out_w  = merge({16'h0, outmap_r[oidx]}, wb_dat_i, wmask);

  wire [31:0] status = {16'h0, grp_r, rmode_r, usb_r, breaker_open_status_o,
                        breaker_closed_status_o, hold_act_r, aux_led_o,
                        trip_led_o, latched_r, relay_r};

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      in1map_r <= `REF_IN1_DEF;
      in2map_r <= `REF_IN2_DEF;
      hold_r   <= `REF_HOLD_DEF;
      outmap_r[0] <= `REF_OUT1_DEF;
      outmap_r[1] <= `REF_OUT2_DEF;
      outmap_r[2] <= `REF_OUT3_DEF;
      outmap_r[3] <= `REF_OUT4_DEF;
    end else if (ce_i) begin
      // Every access is acked, unmapped ones read zero and drop writes
      wb_ack_o <= acc;
      wb_dat_o <= 32'h0000_0000;
      if (acc && !wb_we_i) begin
        case (wb_adr_i)
          `REF_ADR_STATUS: wb_dat_o <= status;
          `REF_ADR_IN1MAP: wb_dat_o <= {21'h0, in1map_r};
          `REF_ADR_IN2MAP: wb_dat_o <= {21'h0, in2map_r};
          `REF_ADR_HOLD:   wb_dat_o <= {19'h0, hold_r};
          default: begin
            if (is_out)
              wb_dat_o <= {16'h0, outmap_r[oidx]};
          end
        endcase
      end
      if (wr) begin
        case (wb_adr_i)
          `REF_ADR_IN1MAP: in1map_r <= in1_w[10:0];  // see R10
          `REF_ADR_IN2MAP: in2map_r <= in2_w[10:0];  // see R10
          `REF_ADR_HOLD: begin
            // Out-of-range hold times clamp to the top of the range
            if (hold_w[31:13] != 19'h0 || hold_w[12:0] > `REF_HOLD_MAX)
              hold_r <= `REF_HOLD_MAX;  // see R22
            else
              hold_r <= hold_w[12:0];  // see R22
          end
          default: begin
            if (is_out)
              outmap_r[oidx] <= {out_w[15], 1'b0, out_w[13:0]};  // see R21
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input function matrix
  wire [10:0] map1 = usb_r ? in1map_r :  // see R07
                     (inset_r ? (11'h001 << `REF_FI_AUX) :  // see R09
                                (11'h001 << `REF_FI_BLKP2));  // see R08
  wire [10:0] map2 = usb_r ? in2map_r : `REF_IN2_DEF;  // see R08 see R09
  wire        r1   = bi1_r & ~bi1_q;
  wire        r2   = bi2_r & ~bi2_q;
  // Both inputs may feed the same function; their effects are ORed  // see R10
  wire [10:0] fn_lvl  = ({11{bi1_r}} & map1) | ({11{bi2_r}} & map2);
  wire [10:0] fn_rise = ({11{r1}} & map1) | ({11{r2}} & map2);

  wire blk_out  = fn_lvl[`REF_FI_BLKOUT];
  wire rst_out  = fn_rise[`REF_FI_RSTOUT];
  wire rst_led  = fn_rise[`REF_FI_RSTLED];
  wire aux_lvl  = fn_lvl[`REF_FI_AUX];
  wire aux_rise = fn_rise[`REF_FI_AUX];
  wire nrdy     = fn_lvl[`REF_FI_NRDY];

  // Aux is an instantaneous trip while the input is energised
  wire any_trip = (|trip_r) | aux_lvl;  // see R15
  reg  any_trip_q;
  wire trip_rise = any_trip & ~any_trip_q;

  ////////////////////////////////////////////////////////////////////////////
  // Common slow timebase
  reg [TW-1:0] tick_cnt_r;
  reg          tick_r;
  reg [9:0]    min_cnt_r;
  reg [2:0]    pulse_cnt_r, close_cnt_r;
  reg [12:0]   hold_cnt_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_r <= {TW{1'b0}};
      tick_r     <= 1'b0;
    end else if (ce_i) begin
      tick_r <= (tick_cnt_r == TICK_LAST);  // see R23
      if (tick_cnt_r == TICK_LAST)
        tick_cnt_r <= {TW{1'b0}};
      else
        tick_cnt_r <= tick_cnt_r + {{(TW-1){1'b0}}, 1'b1};
    end
  end

  // Pulses run from the next tick, so length is 3 to 4 tick periods
  always @(posedge clk_i) begin
    if (rst_i) begin
      any_trip_q  <= 1'b0;
      pulse_cnt_r <= 3'h0;
      close_cnt_r <= 3'h0;
      hold_cnt_r  <= 13'h0;
      min_cnt_r   <= 10'h0;
      hold_act_r  <= 1'b0;
      close_refused_o <= 1'b0;
    end else if (ce_i) begin
      any_trip_q <= any_trip;
      if (trip_rise)
        pulse_cnt_r <= PULSE_T;  // see R17
      else if (tick_r && pulse_cnt_r != 3'h0)
        pulse_cnt_r <= pulse_cnt_r - 3'h1;
      close_refused_o <= close_req_r & nrdy;  // see R16
      if (close_req_r && !nrdy)
        close_cnt_r <= CLOSE_T;
      else if (tick_r && close_cnt_r != 3'h0)
        close_cnt_r <= close_cnt_r - 3'h1;
      // Trip reloads the hold; a reset edge ends it early, trip wins
      if (any_trip) begin
        hold_cnt_r <= hold_r;  // see R18 see R22
        min_cnt_r  <= 10'h0;
        hold_act_r <= (hold_r != 13'h0);
      end else if (rst_out) begin
        hold_cnt_r <= 13'h0;  // see R18
        hold_act_r <= 1'b0;
      end else if (tick_r && hold_act_r) begin
        if (min_cnt_r == MIN_LAST) begin
          min_cnt_r  <= 10'h0;
          hold_cnt_r <= hold_cnt_r - 13'h1;
          hold_act_r <= (hold_cnt_r != 13'h1);
        end else begin
          min_cnt_r <= min_cnt_r + 10'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Relay drive
  wire [13:0] src = {wdog_r, (close_cnt_r != 3'h0), hold_act_r, aux_lvl,
                     trip_r, start_r, any_trip, (pulse_cnt_r != 3'h0)};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_relay
      wire [13:0] g1  = G1_MAPS[14*g +: 14];
      wire [13:0] g2  = G2_MAPS[14*g +: 14];
      // Switch mode picks a fixed set, software mode the written map
      wire [13:0] sel = usb_r ? outmap_r[g][13:0] :  // see R07
                        (outset_r ? g2 : g1);  // see R24 see R17 see R19 see R20
      wire lat_en = usb_r & outmap_r[g][`REF_FO_LATCH];  // see R21
      wire raw    = |(src & sel);
      // One flop pair per relay, so no vector has several writers
      reg  lat_r;
      reg  rel_r;
      assign latched_r[g] = lat_r;
      assign relay_r[g]   = rel_r;
      always @(posedge clk_i) begin
        if (rst_i) begin
          lat_r <= 1'b0;
          rel_r <= 1'b0;
        end else if (ce_i) begin
          if (raw && lat_en)
            lat_r <= 1'b1;
          else if (rst_out)
            lat_r <= 1'b0;  // see R12
          // Blocking wins over every source for test without tripping
          rel_r <= ~blk_out & (raw | (lat_r & ~rst_out));  // see R11
        end
      end
    end
  endgenerate

  assign output_relay_one_o   = relay_r[0];
  assign output_relay_two_o   = relay_r[1];
  assign output_relay_three_o = relay_r[2];
  assign output_relay_four_o  = relay_r[3];

  ////////////////////////////////////////////////////////////////////////////
  // Indicators, stage settings and blocks
  wire [7:0] thr_add = {3'h0, thr_sw_r[4:0]};
  wire [7:0] thr_nxt = thr_sw_r[5] ?
                       (`REF_THR_MIN_HI + (thr_add << 2) + thr_add) :
                       (`REF_THR_MIN_LO + thr_add);

  always @(posedge clk_i) begin
    if (rst_i) begin
      trip_led_o  <= 1'b0;
      aux_led_o   <= 1'b0;
      earth_curve_code_o    <= 4'h0;
      phase_reset_inverse_o <= 1'b0;
      earth_reset_inverse_o <= 1'b0;
      earth_thr_o <= 8'h00;
      earth_stage_one_disable_o <= 1'b0;
      block_phase_one_o <= 1'b0;
      block_phase_two_o <= 1'b0;
      block_earth_one_o <= 1'b0;
      block_earth_two_o <= 1'b0;
      breaker_closed_status_o <= 1'b0;
      breaker_open_status_o   <= 1'b0;
    end else if (ce_i) begin
      // Set beats clear; a live trip cause also keeps it lit
      if (|trip_r)
        trip_led_o <= 1'b1;
      else if (rst_led)
        trip_led_o <= 1'b0;  // see R13
      if (aux_rise)
        aux_led_o <= 1'b1;  // see R15
      else if (rst_led && !any_trip)
        aux_led_o <= 1'b0;  // see R13
      // Group in bit 3, selector in 2:0; stage two has no curve code  // see R06
      earth_curve_code_o <= {grp_r, csel_r};  // see R01 see R02
      phase_reset_inverse_o <= rmode_r;  // see R03 see R04
      earth_reset_inverse_o <= rmode_r;  // see R03 see R04
      earth_thr_o <= thr_nxt;  // see R05
      earth_stage_one_disable_o <= &thr_sw_r;  // see R05
      block_phase_one_o <= fn_lvl[`REF_FI_BLKP1];  // see R14
      block_phase_two_o <= fn_lvl[`REF_FI_BLKP2];  // see R14 see R08
      block_earth_one_o <= fn_lvl[`REF_FI_BLKE1];  // see R14
      block_earth_two_o <= fn_lvl[`REF_FI_BLKE2];  // see R14
      breaker_closed_status_o <= fn_lvl[`REF_FI_CLOSED];
      breaker_open_status_o   <= fn_lvl[`REF_FI_OPEN];
    end
  end

endmodule // ref_io_config

// File: ref_io_config_properties.sv
`timescale 1ns/1ps
module ref_io_chk #(
  parameter TICK_CYCLES = 10
) (
  input wire       clk_i,
  input wire       rst_i,
  input wire       ce_i,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o,
  input wire       sw_char_group_i,
  input wire [2:0] sw_char_sel_i,
  input wire       sw_reset_mode_i,
  input wire       sw_io_source_i,
  input wire       sw_input_set_i,
  input wire       sw_output_set_i,
  input wire [5:0] sw_earth_thr_i,
  input wire       binary_input_one_i,
  input wire       earth_stage_one_trip_i,
  input wire       earth_stage_two_trip_i,
  input wire       phase_stage_two_start_i,
  input wire       close_req_i,
  input wire [3:0] earth_curve_code_o,
  input wire       phase_reset_inverse_o,
  input wire       earth_reset_inverse_o,
  input wire [7:0] earth_thr_o,
  input wire       block_phase_two_o,
  input wire       output_relay_one_o,
  input wire       output_relay_two_o,
  input wire       output_relay_four_o,
  input wire       close_refused_o
);
  localparam int PMIN = 3 * TICK_CYCLES;
  localparam int PMAX = 4 * TICK_CYCLES + 4;
  logic [31:0]   hi_cnt_r;
  logic [1:0]    rst_d_r = 2'b11;
  wire           g1 = !sw_io_source_i && !sw_output_set_i;
  wire [7:0]     w = {3'h0, sw_earth_thr_i[4:0]};
  wire [7:0]     thr = sw_earth_thr_i[5] ? 8'h1e + 8'h05 * w : 8'h01 + w;
  //////////////////////////////////////////
  // Pulse width counter; a fixed tick count would hide a stuck pulse
  always @(posedge clk_i) begin
    rst_d_r <= {rst_d_r[0], rst_i};
    if (rst_i) begin
      hi_cnt_r <= 32'h0;
    end else begin
      hi_cnt_r <= output_relay_one_o ? hi_cnt_r + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence sw_held;
    // Settings outputs trail the switches by two clocks after a reset
    (rst_d_r == 2'b00) ##0 ($stable({sw_char_group_i, sw_char_sel_i, sw_reset_mode_i, sw_earth_thr_i}))[*3];
  endsequence
  AST_CURVE: assert property (sw_held |-> earth_curve_code_o == {sw_char_group_i, sw_char_sel_i})
    else $error("curve code");
  AST_RMODE: assert property (sw_held |-> earth_reset_inverse_o == sw_reset_mode_i)
    else $error("reset mode");
  AST_SHARED: assert property (phase_reset_inverse_o == earth_reset_inverse_o)
    else $error("reset mode split");
  AST_THR: assert property (sw_held |-> sw_earth_thr_i == 6'h3f || earth_thr_o == thr)
    else $error("threshold");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing");
  AST_BLK: assert property ((!sw_io_source_i && $stable({sw_io_source_i, sw_input_set_i, binary_input_one_i}))[*3]
    |-> block_phase_two_o == (binary_input_one_i && !sw_input_set_i))
    else $error("phase two block");
  AST_G2: assert property ((!sw_io_source_i && sw_output_set_i && $stable({sw_io_source_i, sw_output_set_i,
    earth_stage_one_trip_i, earth_stage_two_trip_i}))[*4]
    |-> output_relay_two_o == (earth_stage_one_trip_i || earth_stage_two_trip_i))
    else $error("relay two group two");
  AST_G1R4: assert property ((g1 && $stable({sw_io_source_i, sw_output_set_i, phase_stage_two_start_i}))[*4]
    |-> output_relay_four_o == phase_stage_two_start_i)
    else $error("relay four group one");
  AST_PMAX: assert property (output_relay_one_o && g1 |-> hi_cnt_r < PMAX)
    else $error("pulse too long");
  AST_PMIN: assert property ($fell(output_relay_one_o) && g1 |-> hi_cnt_r >= PMIN)
    else $error("pulse too short");
  AST_REFUSE: assert property (close_refused_o |-> $past(close_req_i) || $past(close_req_i, 2))
    else $error("refusal without request");
  AST_REF1: assert property (close_refused_o |=> !close_refused_o)
    else $error("refusal pulse width");
  COV_ACK: cover property (wb_ack_o);
  COV_PULSE: cover property ($fell(output_relay_one_o) && g1);
  COV_REF: cover property (close_refused_o);
  COV_BLK: cover property (block_phase_two_o);
endmodule // ref_io_chk
bind ref_io_config ref_io_chk #(.TICK_CYCLES(TICK_CYCLES)) ref_io_chk_i (.*);

// File: ref_plant.sv
`timescale 1ns/1ps
module ref_plant (
  input  wire  clk_i,
  input  wire  coil_i,
  input  wire  wire_one_i,
  input  wire  wire_two_i,
  output logic bin_one_o,
  output logic bin_two_o,
  output logic cb_open_o
);
  initial begin
    bin_one_o = 1'b0;
    bin_two_o = 1'b0;
    cb_open_o = 1'b0;
  end
  // Field wiring reaches the pins one clock late; the breaker never recloses itself
  always @(posedge clk_i) begin
    bin_one_o <= wire_one_i;
    bin_two_o <= wire_two_i;
    cb_open_o <= cb_open_o | coil_i;
  end
endmodule // ref_plant

// File: ref_io_config_bench.sv
`timescale 1ns/1ps
`include "ref_defines.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t %h/%h", $time, a, b); end end
module ref_io_config_bench;
  logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic        sw_char_group_i = 1'b0, sw_reset_mode_i = 1'b0, sw_io_source_i = 1'b0;
  logic        sw_input_set_i = 1'b0, sw_output_set_i = 1'b0, watchdog_ok_i = 1'b1, close_req_i = 1'b0;
  logic [2:0]  sw_char_sel_i = 3'h0;
  logic [5:0]  sw_earth_thr_i = 6'h00;
  logic        phase_stage_one_trip_i = 1'b0, phase_stage_two_trip_i = 1'b0, earth_stage_one_trip_i = 1'b0;
  logic        earth_stage_two_trip_i = 1'b0, phase_stage_one_start_i = 1'b0, phase_stage_two_start_i = 1'b0;
  logic        earth_stage_one_start_i = 1'b0, earth_stage_two_start_i = 1'b0, w1 = 1'b0, w2 = 1'b0;
  wire  [31:0] wb_dat_o;
  wire  [3:0]  earth_curve_code_o;
  wire  [7:0]  earth_thr_o;
  wire         wb_ack_o, binary_input_one_i, binary_input_two_i, phase_reset_inverse_o, earth_reset_inverse_o;
  wire         earth_stage_one_disable_o, block_phase_one_o, block_phase_two_o, block_earth_one_o;
  wire         block_earth_two_o, output_relay_one_o, output_relay_two_o, output_relay_three_o;
  wire         output_relay_four_o, trip_led_o, aux_led_o, breaker_closed_status_o, breaker_open_status_o;
  wire         close_refused_o, cb_open;
  int          error_cnt = 0, n_tests = 0;
  ref_io_config #(.TICK_CYCLES(10)) ref_io_config_i (.*);
  ref_plant ref_plant_i (.clk_i(clk_i), .coil_i(output_relay_one_o), .wire_one_i(w1), .wire_two_i(w2),
    .bin_one_o(binary_input_one_i), .bin_two_o(binary_input_two_i), .cb_open_o(cb_open));
  always #2 clk_i = ~clk_i;
  //////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  // Reset lines are edge sensitive, so the wire must fall again
  task automatic rst_two();
    w2 <= 1'b1;
    cyc(6);
    w2 <= 1'b0;
    cyc(6);
  endtask
  task automatic relays(input logic [3:0] e);
    `CHK({output_relay_four_o, output_relay_three_o, output_relay_two_o, output_relay_one_o}, e)
  endtask
  //////////////////////////////////////////
  task automatic t_regs();
    rd(`REF_ADR_IN1MAP, 32'h010);
    rd(`REF_ADR_IN2MAP, 32'h006);
    rd(`REF_ADR_HOLD, 32'd4320);
    rd(8'h10, 32'h0001);
    rd(8'h14, 32'h0002);
    rd(8'h18, 32'h0800);
    rd(8'h1c, 32'h0008);
    wr(`REF_ADR_HOLD, 32'd7000);
    rd(`REF_ADR_HOLD, 32'd6500);
    wr(8'h10, 32'hffff);
    rd(8'h10, 32'hbfff);
    wr(8'h10, 32'h0001);
    wr(8'h40, 32'h1234);
    rd(8'h40, 32'h0);
  endtask
  task automatic t_switch();
    logic [7:0] w;
    logic [7:0] e;
    for (int i = 0; i < 16; i++) begin
      w = {3'h0, i[3:0], i[0]};
      e = i[1] ? 8'h1e + 8'h05 * w : 8'h01 + w;
      sw_char_group_i <= i[3];
      sw_char_sel_i <= i[2:0];
      sw_reset_mode_i <= i[0];
      sw_earth_thr_i <= {i[1], w[4:0]};
      cyc(4);
      `CHK(earth_curve_code_o, i[3:0])
      `CHK({phase_reset_inverse_o, earth_reset_inverse_o}, {2{i[0]}})
      if (i == 15) begin
        `CHK(earth_stage_one_disable_o, 1'b1)
      end else begin
        `CHK(earth_thr_o, e)
      end
    end
  endtask
  task automatic t_group1();
    phase_stage_one_trip_i <= 1'b1;
    cyc(5);
    relays(4'h7);
    `CHK(cb_open, 1'b1)
    cyc(50);
    relays(4'h6);
    rst_two();
    `CHK({trip_led_o, output_relay_three_o}, 2'b11)
    phase_stage_one_trip_i <= 1'b0;
    cyc(5);
    relays(4'h4);
    rst_two();
    `CHK({trip_led_o, output_relay_three_o}, 2'b00)
    phase_stage_two_start_i <= 1'b1;
    w1 <= 1'b1;
    cyc(6);
    relays(4'h8);
    `CHK({block_phase_one_o, block_phase_two_o}, 2'b01)
    phase_stage_two_start_i <= 1'b0;
    w1 <= 1'b0;
    cyc(6);
    `CHK(block_phase_two_o, 1'b0)
  endtask
  task automatic t_group2();
    sw_output_set_i <= 1'b1;
    sw_input_set_i <= 1'b1;
    earth_stage_one_trip_i <= 1'b1;
    cyc(5);
    relays(4'ha);
    earth_stage_one_trip_i <= 1'b0;
    w1 <= 1'b1;
    cyc(6);
    relays(4'h5);
    `CHK({aux_led_o, block_phase_two_o}, 2'b10)
    w1 <= 1'b0;
    cyc(6);
    relays(4'h0);
    `CHK(aux_led_o, 1'b1)
    rst_two();
    `CHK(aux_led_o, 1'b0)
  endtask
  task automatic t_soft();
    logic s;
    sw_io_source_i <= 1'b1;
    w1 <= 1'b1;
    cyc(6);
    `CHK({aux_led_o, block_phase_two_o}, 2'b01)
    wr(`REF_ADR_IN1MAP, 32'h5e1);
    earth_stage_two_trip_i <= 1'b1;
    cyc(6);
    `CHK({block_earth_one_o, block_earth_two_o, breaker_closed_status_o, breaker_open_status_o}, 4'hf)
    relays(4'h0);
    for (int k = 0; k < 2; k++) begin
      close_req_i <= 1'b1;
      @(posedge clk_i);
      close_req_i <= 1'b0;
      s = 1'b0;
      repeat (4) begin
        @(posedge clk_i);
        s = s | close_refused_o;
      end
      `CHK(s, k == 0)
      w1 <= 1'b0;
      cyc(6);
    end
    relays(4'h7);
    earth_stage_two_trip_i <= 1'b0;
    wr(8'h10, 32'h8040);
    phase_stage_one_trip_i <= 1'b1;
    cyc(5);
    phase_stage_one_trip_i <= 1'b0;
    cyc(5);
    relays(4'h5);
    rst_two();
    relays(4'h0);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////
  initial begin
    cyc(20);
    rst_i <= 1'b0;
    cyc(1);
    t_regs();
    t_switch();
    t_group1();
    t_group2();
    t_soft();
    rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    cyc(1);
    rd(`REF_ADR_IN1MAP, 32'h010);
    summarize();
  end
  initial begin
    cyc(20000);
    error_cnt++;
    summarize();
  end
endmodule // ref_io_config_bench
